// >>> common/spi_slave_buffer_semaphore_map.vh
`ifndef SPI_SLAVE_BUFFER_SEMAPHORE_MAP_VH
`define SPI_SLAVE_BUFFER_SEMAPHORE_MAP_VH

// Register byte offsets
`define OFS_TASK_TAKE 12'h024
`define OFS_TASK_GIVE 12'h028
`define OFS_SUB_TAKE 12'h0A4
`define OFS_SUB_GIVE 12'h0A8
`define OFS_EV_DONE 12'h104
`define OFS_EV_RX_FULL 12'h110
`define OFS_EV_GRANTED 12'h128
`define OFS_PUB_DONE 12'h184
`define OFS_PUB_RX_FULL 12'h190
`define OFS_PUB_GRANTED 12'h1A8
`define OFS_EVENT_TASK_SHORTCUTS 12'h200
`define OFS_IRQ_SET 12'h304
`define OFS_IRQ_CLR 12'h308
`define OFS_SEM_STATUS 12'h400
`define OFS_XFER_STATUS 12'h440
`define OFS_ENABLE 12'h500
`define OFS_ROUTE_CLOCK 12'h508
`define OFS_ROUTE_OUT 12'h50C
`define OFS_ROUTE_IN 12'h510
`define OFS_ROUTE_SELECT 12'h514
`define OFS_RX_PTR 12'h534
`define OFS_RX_LIMIT 12'h538
`define OFS_RX_COUNT 12'h53C
`define OFS_RX_LIST 12'h540
`define OFS_TX_PTR 12'h544
`define OFS_TX_LIMIT 12'h548
`define OFS_TX_COUNT 12'h54C
`define OFS_TX_LIST 12'h550
`define OFS_MODE 12'h554
`define OFS_IGNORED_FILL 12'h55C
`define OFS_OVERRUN_FILL 12'h5C0
// Buffer memory window: one byte per word from here
`define MEM_WIN_TAG 4'h8

// Field positions
`define SHORT_END_TAKE_BIT 0
`define ST_TX_EXCESS_FLAG_BIT 0
`define ST_OVERFLOW_BIT 1
`define MODE_CPHA_BIT 0
`define MODE_CPOL_BIT 1
`define ROUTE_DISC_BIT 31
`define ENABLE_ON 4'h2

// Semaphore status codes
`define SEM_FREE 2'h0
`define SEM_CPU 2'h1
`define SEM_SPI 2'h2
`define SEM_SPI_CPU_WAIT 2'h3

// Reset values
`define ROUTE_RESET 32'h80000000
`define ZERO_RESET 32'h00000000
`define FILL_RESET 8'h00

`endif

// >>> design/spi_slave_buffer_semaphore.v
// The APB interface to the registers was decided locally.
`timescale 1ns/1ps
`include "spi_slave_buffer_semaphore_map.vh"

module spi_slave_buffer_semaphore #(
    parameter PIN_COUNT = 32,
    parameter PIN_W = 5,
    parameter MEM_AW = 6,
    parameter CNT_W = 16
) (
    input wire core_clk,
    input wire reset_n,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire [PIN_COUNT-1:0] pin_in,
    input wire [PIN_COUNT-1:0] gpio_out,
    input wire [PIN_COUNT-1:0] gpio_oe_n,
    output reg [PIN_COUNT-1:0] pin_out,
    output reg [PIN_COUNT-1:0] pin_oe_n
);

localparam OWN_FREE = 3'b001;
localparam OWN_CPU = 3'b010;
localparam OWN_SPI = 3'b100;

////////////////////////////////////////////////////////////////////////////////
// Registers
reg [3:0] enable_r;
reg enabled_d_r;
reg event_task_shortcuts_r;
reg [31:0] sub_take_r, sub_give_r, pub_done_r, pub_rxf_r, pub_grant_r;
reg [2:0] irq_en_r;
reg [31:0] route_clk_r, route_out_r, route_in_r, route_sel_r;
reg [31:0] rx_ptr_r, tx_ptr_r;
reg [CNT_W-1:0] rx_lim_r, tx_lim_r, rx_amt_r, tx_amt_r;
reg [1:0] rx_list_r, tx_list_r;
reg [1:0] mode_r;
reg [7:0] ign_fill_r, ovr_fill_r;
reg ev_done_r, ev_rxf_r, ev_grant_r;
reg st_tx_excess_flag_r, st_overflow_r;
reg [2:0] owner_r;
reg take_pend_r;
reg granted_r;
reg in_frame_r;
reg [2:0] bit_cnt_r;
reg [7:0] rx_sh_r, tx_sh_r;
reg [CNT_W-1:0] rx_cnt_r, tx_cnt_r;
reg [7:0] mem [0:(1<<MEM_AW)-1];
reg csn_s1_r, csn_s2_r, csn_d_r;
reg sck_s1_r, sck_s2_r, sck_d_r;
reg mosi_s1_r, mosi_s2_r;

wire enabled = (enable_r == `ENABLE_ON);
wire cpha = mode_r[`MODE_CPHA_BIT];
wire cpol = mode_r[`MODE_CPOL_BIT];

////////////////////////////////////////////////////////////////////////////////
// Pin routing and input synchronisers
// Unrouted inputs fall back to the idle levels so no false frame is seen
wire csn_raw = (enabled && !route_sel_r[`ROUTE_DISC_BIT]) ? pin_in[route_sel_r[PIN_W-1:0]] : 1'b1;
wire sck_raw = (enabled && !route_clk_r[`ROUTE_DISC_BIT]) ? pin_in[route_clk_r[PIN_W-1:0]] : cpol;
wire mosi_raw = (enabled && !route_in_r[`ROUTE_DISC_BIT]) ? pin_in[route_in_r[PIN_W-1:0]] : 1'b0;

always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
        csn_s1_r <= 1'b1;
        csn_s2_r <= 1'b1;
        csn_d_r <= 1'b1;
        sck_s1_r <= 1'b0;
        sck_s2_r <= 1'b0;
        sck_d_r <= 1'b0;
        mosi_s1_r <= 1'b0;
        mosi_s2_r <= 1'b0;
    end else begin
        csn_s1_r <= csn_raw;
        csn_s2_r <= csn_s1_r;
        csn_d_r <= csn_s2_r;
        sck_s1_r <= sck_raw;
        sck_s2_r <= sck_s1_r;
        sck_d_r <= sck_s2_r;
        mosi_s1_r <= mosi_raw;
        mosi_s2_r <= mosi_s1_r;
    end
end

wire cs_fall = !csn_s2_r && csn_d_r;
wire cs_rise = csn_s2_r && !csn_d_r;
wire sck_rise = sck_s2_r && !sck_d_r;
wire sck_fall = !sck_s2_r && sck_d_r;
wire lead_edge = cpol ? sck_fall : sck_rise;
wire trail_edge = cpol ? sck_rise : sck_fall;
wire sample_edge = in_frame_r && (cpha ? trail_edge : lead_edge);
wire shift_edge = in_frame_r && (cpha ? lead_edge : trail_edge);

////////////////////////////////////////////////////////////////////////////////
// APB decode
wire wr_en = psel && penable && pready && pwrite;
wire take_task = wr_en && (paddr == `OFS_TASK_TAKE) && pwdata[0];
wire give_task = wr_en && (paddr == `OFS_TASK_GIVE) && pwdata[0];

////////////////////////////////////////////////////////////////////////////////
// Semaphore
reg [2:0] owner_nxt;
reg take_pend_nxt;
reg granted_nxt;
reg grant_ev;
reg done_ev;

always @* begin
    owner_nxt = owner_r;
    take_pend_nxt = take_pend_r;
    granted_nxt = granted_r;
    grant_ev = 1'b0;
    done_ev = 1'b0;
    if (!enabled) begin
        owner_nxt = OWN_FREE;
        take_pend_nxt = 1'b0;
        granted_nxt = 1'b0;
    end else if (!enabled_d_r) begin
        owner_nxt = OWN_CPU;
    end else begin
        case (owner_r)
            OWN_CPU: begin
                if (take_task)
                    grant_ev = 1'b1;
                else if (give_task)
                    owner_nxt = OWN_FREE;
            end
            OWN_FREE: begin
                if (take_task) begin
                    owner_nxt = OWN_CPU;
                    grant_ev = 1'b1;
                end
            end
            OWN_SPI: begin
                if (take_task)
                    take_pend_nxt = 1'b1;
            end
            default: owner_nxt = OWN_FREE;
        endcase
        // Give from a non-owner falls through the case untouched
        if (cs_fall) begin
            if (owner_r == OWN_FREE && !take_task) begin
                owner_nxt = OWN_SPI;
                granted_nxt = 1'b1;
            end else begin
                granted_nxt = 1'b0;
            end
        end
        if (cs_rise && granted_r) begin
            done_ev = 1'b1;
            granted_nxt = 1'b0;
            take_pend_nxt = 1'b0;
            // Pending take and shortcut merge into one grant
            if (take_pend_r || take_task || event_task_shortcuts_r) begin
                owner_nxt = OWN_CPU;
                grant_ev = 1'b1;
            end else begin
                owner_nxt = OWN_FREE;
            end
        end
    end
end

always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
        owner_r <= OWN_FREE;
        take_pend_r <= 1'b0;
        granted_r <= 1'b0;
        enabled_d_r <= 1'b0;
    end else begin
        owner_r <= owner_nxt;
        take_pend_r <= take_pend_nxt;
        granted_r <= granted_nxt;
        enabled_d_r <= enabled;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Serial engine
wire [MEM_AW-1:0] rx_addr = rx_ptr_r[MEM_AW-1:0] + rx_cnt_r[MEM_AW-1:0];
wire byte_done = sample_edge && (bit_cnt_r == 3'd7);
wire rx_store = byte_done && granted_r && (rx_cnt_r < rx_lim_r);
wire overflow_ev = byte_done && granted_r && !(rx_cnt_r < rx_lim_r);
wire tx_excess_flag_ev = byte_done && granted_r && !(tx_cnt_r < tx_lim_r);
wire rxf_ev = rx_store && (rx_cnt_r + 1'b1 == rx_lim_r);
wire [CNT_W-1:0] tx_idx = cs_fall ? {CNT_W{1'b0}} : tx_cnt_r;
wire [MEM_AW-1:0] tx_addr = tx_ptr_r[MEM_AW-1:0] + tx_idx[MEM_AW-1:0];
reg [7:0] tx_next;

always @* begin
    if (!granted_nxt)
        tx_next = ign_fill_r;
    else if (tx_idx < tx_lim_r)
        tx_next = mem[tx_addr];
    else
        tx_next = ovr_fill_r;
end

always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
        in_frame_r <= 1'b0;
        bit_cnt_r <= 3'd0;
        rx_sh_r <= 8'h00;
        tx_sh_r <= 8'h00;
        rx_cnt_r <= {CNT_W{1'b0}};
        tx_cnt_r <= {CNT_W{1'b0}};
        rx_amt_r <= {CNT_W{1'b0}};
        tx_amt_r <= {CNT_W{1'b0}};
    end else if (cs_fall) begin
        in_frame_r <= 1'b1;
        bit_cnt_r <= 3'd0;
        rx_cnt_r <= {CNT_W{1'b0}};
        tx_cnt_r <= {CNT_W{1'b0}};
        tx_sh_r <= tx_next;
    end else begin
        if (cs_rise || !enabled)
            in_frame_r <= 1'b0;
        if (cs_rise && granted_r) begin
            rx_amt_r <= rx_cnt_r;
            tx_amt_r <= tx_cnt_r;
        end
        if (sample_edge) begin
            rx_sh_r <= {rx_sh_r[6:0], mosi_s2_r};
            bit_cnt_r <= bit_cnt_r + 3'd1;
        end
        if (rx_store)
            rx_cnt_r <= rx_cnt_r + 1'b1;
        if (byte_done && granted_r && (tx_cnt_r < tx_lim_r))
            tx_cnt_r <= tx_cnt_r + 1'b1;
        if (shift_edge) begin
            if (bit_cnt_r == 3'd0)
                tx_sh_r <= tx_next;
            else
                tx_sh_r <= {tx_sh_r[6:0], 1'b0};
        end
    end
end

// Engine write wins only if both hit one byte in the same cycle
always @(posedge core_clk) begin
    if (wr_en && paddr[11:8] == `MEM_WIN_TAG)
        mem[paddr[MEM_AW+1:2]] <= pwdata[7:0];
    if (rx_store)
        mem[rx_addr] <= {rx_sh_r[6:0], mosi_s2_r};
end

////////////////////////////////////////////////////////////////////////////////
// Pin outputs
integer i;
always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
        pin_out <= {PIN_COUNT{1'b0}};
        pin_oe_n <= {PIN_COUNT{1'b1}};
    end else begin
        for (i = 0; i < PIN_COUNT; i = i + 1) begin
            if (enabled && !route_out_r[`ROUTE_DISC_BIT] && route_out_r[PIN_W-1:0] == i[PIN_W-1:0]) begin
                pin_out[i] <= tx_sh_r[7];
                pin_oe_n[i] <= csn_s2_r;
            end else begin
                pin_out[i] <= gpio_out[i];
                pin_oe_n[i] <= gpio_oe_n[i];
            end
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Register file
always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
        enable_r <= 4'h0;
        event_task_shortcuts_r <= 1'b0;
        sub_take_r <= `ZERO_RESET;
        sub_give_r <= `ZERO_RESET;
        pub_done_r <= `ZERO_RESET;
        pub_rxf_r <= `ZERO_RESET;
        pub_grant_r <= `ZERO_RESET;
        irq_en_r <= 3'h0;
        route_clk_r <= `ROUTE_RESET;
        route_out_r <= `ROUTE_RESET;
        route_in_r <= `ROUTE_RESET;
        route_sel_r <= `ROUTE_RESET;
        rx_ptr_r <= `ZERO_RESET;
        tx_ptr_r <= `ZERO_RESET;
        rx_lim_r <= {CNT_W{1'b0}};
        tx_lim_r <= {CNT_W{1'b0}};
        rx_list_r <= 2'h0;
        tx_list_r <= 2'h0;
        mode_r <= 2'h0;
        ign_fill_r <= `FILL_RESET;
        ovr_fill_r <= `FILL_RESET;
    end else if (wr_en) begin
        case (paddr)
            `OFS_ENABLE: enable_r <= pwdata[3:0];
            `OFS_EVENT_TASK_SHORTCUTS: event_task_shortcuts_r <= pwdata[`SHORT_END_TAKE_BIT];
            `OFS_SUB_TAKE: sub_take_r <= pwdata;
            `OFS_SUB_GIVE: sub_give_r <= pwdata;
            `OFS_PUB_DONE: pub_done_r <= pwdata;
            `OFS_PUB_RX_FULL: pub_rxf_r <= pwdata;
            `OFS_PUB_GRANTED: pub_grant_r <= pwdata;
            `OFS_IRQ_SET: irq_en_r <= irq_en_r | pwdata[2:0];
            `OFS_IRQ_CLR: irq_en_r <= irq_en_r & ~pwdata[2:0];
            `OFS_ROUTE_CLOCK: route_clk_r <= pwdata;
            `OFS_ROUTE_OUT: route_out_r <= pwdata;
            `OFS_ROUTE_IN: route_in_r <= pwdata;
            `OFS_ROUTE_SELECT: route_sel_r <= pwdata;
            `OFS_RX_PTR: rx_ptr_r <= pwdata;
            `OFS_TX_PTR: tx_ptr_r <= pwdata;
            `OFS_RX_LIMIT: rx_lim_r <= pwdata[CNT_W-1:0];
            `OFS_TX_LIMIT: tx_lim_r <= pwdata[CNT_W-1:0];
            `OFS_RX_LIST: rx_list_r <= pwdata[1:0];
            `OFS_TX_LIST: tx_list_r <= pwdata[1:0];
            `OFS_MODE: mode_r <= pwdata[1:0];
            `OFS_IGNORED_FILL: ign_fill_r <= pwdata[7:0];
            `OFS_OVERRUN_FILL: ovr_fill_r <= pwdata[7:0];
            default: ;
        endcase
    end
end

// Events and status flags: a hardware set beats a software clear
always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
        ev_done_r <= 1'b0;
        ev_rxf_r <= 1'b0;
        ev_grant_r <= 1'b0;
        st_tx_excess_flag_r <= 1'b0;
        st_overflow_r <= 1'b0;
    end else begin
        ev_done_r <= done_ev | ((wr_en && paddr == `OFS_EV_DONE) ? pwdata[0] : ev_done_r);
        ev_rxf_r <= rxf_ev | ((wr_en && paddr == `OFS_EV_RX_FULL) ? pwdata[0] : ev_rxf_r);
        ev_grant_r <= grant_ev | ((wr_en && paddr == `OFS_EV_GRANTED) ? pwdata[0] : ev_grant_r);
        st_tx_excess_flag_r <= tx_excess_flag_ev |
            (st_tx_excess_flag_r & ~(wr_en && paddr == `OFS_XFER_STATUS && pwdata[`ST_TX_EXCESS_FLAG_BIT]));
        st_overflow_r <= overflow_ev |
            (st_overflow_r & ~(wr_en && paddr == `OFS_XFER_STATUS && pwdata[`ST_OVERFLOW_BIT]));
    end
end

reg [31:0] rd_val;
reg rd_hit;
always @* begin
    rd_val = 32'h00000000;
    rd_hit = 1'b1;
    if (paddr[11:8] == `MEM_WIN_TAG && (paddr[7:2] >> MEM_AW) == 6'h00) begin
        rd_val[7:0] = mem[paddr[MEM_AW+1:2]];
    end else begin
        case (paddr)
            `OFS_TASK_TAKE, `OFS_TASK_GIVE: rd_val = 32'h00000000;
            `OFS_SUB_TAKE: rd_val = sub_take_r;
            `OFS_SUB_GIVE: rd_val = sub_give_r;
            `OFS_EV_DONE: rd_val[0] = ev_done_r;
            `OFS_EV_RX_FULL: rd_val[0] = ev_rxf_r;
            `OFS_EV_GRANTED: rd_val[0] = ev_grant_r;
            `OFS_PUB_DONE: rd_val = pub_done_r;
            `OFS_PUB_RX_FULL: rd_val = pub_rxf_r;
            `OFS_PUB_GRANTED: rd_val = pub_grant_r;
            `OFS_EVENT_TASK_SHORTCUTS: rd_val[`SHORT_END_TAKE_BIT] = event_task_shortcuts_r;
            `OFS_IRQ_SET, `OFS_IRQ_CLR: rd_val[2:0] = irq_en_r;
            `OFS_SEM_STATUS: begin
                if (owner_r == OWN_CPU)
                    rd_val[1:0] = `SEM_CPU;
                else if (owner_r == OWN_SPI)
                    rd_val[1:0] = take_pend_r ? `SEM_SPI_CPU_WAIT : `SEM_SPI;
                else
                    rd_val[1:0] = `SEM_FREE;
            end
            `OFS_XFER_STATUS: begin
                rd_val[`ST_TX_EXCESS_FLAG_BIT] = st_tx_excess_flag_r;
                rd_val[`ST_OVERFLOW_BIT] = st_overflow_r;
            end
            `OFS_ENABLE: rd_val[3:0] = enable_r;
            `OFS_ROUTE_CLOCK: rd_val = route_clk_r;
            `OFS_ROUTE_OUT: rd_val = route_out_r;
            `OFS_ROUTE_IN: rd_val = route_in_r;
            `OFS_ROUTE_SELECT: rd_val = route_sel_r;
            `OFS_RX_PTR: rd_val = rx_ptr_r;
            `OFS_RX_LIMIT: rd_val[CNT_W-1:0] = rx_lim_r;
            `OFS_RX_COUNT: rd_val[CNT_W-1:0] = rx_amt_r;
            `OFS_RX_LIST: rd_val[1:0] = rx_list_r;
            `OFS_TX_PTR: rd_val = tx_ptr_r;
            `OFS_TX_LIMIT: rd_val[CNT_W-1:0] = tx_lim_r;
            `OFS_TX_COUNT: rd_val[CNT_W-1:0] = tx_amt_r;
            `OFS_TX_LIST: rd_val[1:0] = tx_list_r;
            `OFS_MODE: rd_val[1:0] = mode_r;
            `OFS_IGNORED_FILL: rd_val[7:0] = ign_fill_r;
            `OFS_OVERRUN_FILL: rd_val[7:0] = ovr_fill_r;
            default: rd_hit = 1'b0;
        endcase
    end
end

// Answer captured in the setup phase: one access cycle, no wait states
always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
        prdata <= 32'h00000000;
        pready <= 1'b0;
        pslverr <= 1'b0;
    end else begin
        pready <= psel && !penable;
        pslverr <= psel && !penable && !rd_hit;
        if (psel && !penable && !pwrite)
            prdata <= rd_val;
    end
end

endmodule // spi_slave_buffer_semaphore

// >>> tb/spi_master_model.sv
`timescale 1ns/1ps
module spi_master_model (
    output logic csn,
    output logic sck,
    output logic mosi,
    input wire logic miso
);
    logic [7:0] rx_q[$];
    initial begin
        csn = 1'b1;
        sck = 1'b0;
        mosi = 1'b0;
    end
    // Mode 0 at 125 ns; sck stands still outside frames
    task automatic frame(input logic [7:0] txb[$]);
        logic [7:0] r;
        csn = 1'b0;
        #200;
        foreach (txb[i]) begin
            for (int j = 7; j >= 0; j--) begin
                mosi = txb[i][j];
                #62.5 sck = 1'b1;
                r = {r[6:0], miso};
                #62.5 sck = 1'b0;
            end
            rx_q.push_back(r);
        end
        // Released line must not keep showing the last bit
        mosi = ~mosi;
        #100 csn = 1'b1;
        #100;
    endtask
endmodule // spi_master_model

// >>> tb/spi_slave_buffer_semaphore_monitor.sv
`timescale 1ns/1ps
module spi_slave_buffer_semaphore_monitor #(
    parameter PIN_COUNT = 32
) (
    input wire core_clk,
    input wire reset_n,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire [PIN_COUNT-1:0] pin_in,
    input wire [PIN_COUNT-1:0] gpio_out,
    input wire [PIN_COUNT-1:0] gpio_oe_n,
    input wire [PIN_COUNT-1:0] pin_out,
    input wire [PIN_COUNT-1:0] pin_oe_n
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    ////////////////////////////////////////////////////////////////////////////////
    chk_ready_setup: assert property (psel && !penable |=> pready)
        else $error("pready missing after setup");
    chk_ready_pulse: assert property (pready |=> !pready)
        else $error("pready held too long");
    chk_ready_cause: assert property (pready |-> $past(psel && !penable))
        else $error("pready without setup");
    chk_err_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    chk_unmapped_err: assert property (psel && !penable && paddr == 12'hFFC |=> pslverr)
        else $error("unmapped address accepted");
    chk_unmapped_zero: assert property (pslverr && !pwrite |-> prdata == 32'h00000000)
        else $error("unmapped read not zero");
    // Six cycles covers the two csn sync flops and the output register
    chk_miso_idle: assert property ((pin_in[0] && gpio_oe_n[3]) [*6] |-> pin_oe_n[3])
        else $error("miso driven while deselected");
    chk_gpio_pass: assert property ($past(reset_n) |-> pin_out[PIN_COUNT-1:4] == $past(gpio_out[PIN_COUNT-1:4])
        && pin_oe_n[PIN_COUNT-1:4] == $past(gpio_oe_n[PIN_COUNT-1:4]))
        else $error("unrouted pin not following gpio");
endmodule // spi_slave_buffer_semaphore_monitor

bind spi_slave_buffer_semaphore spi_slave_buffer_semaphore_monitor #(.PIN_COUNT(PIN_COUNT)) mon_inst (
    .core_clk, .reset_n, .psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr,
    .pin_in, .gpio_out, .gpio_oe_n, .pin_out, .pin_oe_n);

// >>> tb/spi_slave_buffer_semaphore_tb.sv
`timescale 1ns/1ps
`include "spi_slave_buffer_semaphore_map.vh"
module spi_slave_buffer_semaphore_tb;
    logic core_clk;
    logic reset_n;
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] gpio_out;
    logic [31:0] gpio_oe_n;
    wire [31:0] prdata;
    wire pready;
    wire pslverr;
    wire [31:0] pin_out;
    wire [31:0] pin_oe_n;
    wire csn;
    wire sck;
    wire mosi;
    wire miso;
    wire [31:0] pin_in;
    logic [31:0] q;
    logic e;
    int error_cnt;
    int check_count;
    assign miso = pin_oe_n[3] ? 1'bz : pin_out[3];
    assign pin_in = {29'h00000000, mosi, sck, csn};
    spi_slave_buffer_semaphore spi_slave_buffer_semaphore_inst (.core_clk, .reset_n, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .pin_in, .gpio_out, .gpio_oe_n,
        .pin_out, .pin_oe_n);
    spi_master_model spi_master_model_inst (.csn, .sck, .mosi, .miso);
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        k = 0;
        #1;
        while (pready !== 1'b1 && k < 20) begin
            @(posedge core_clk);
            #1;
            k++;
        end
        if (k == 20) begin
            error_cnt++;
            test_done;
        end
        e = pslverr;
        @(posedge core_clk);
        // Read data taken at the edge that completes the access
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h00000000);
        chk(q, exp);
    endtask
    task automatic sem(input logic [1:0] s);
        rd(`OFS_SEM_STATUS, {30'h00000000, s});
    endtask
    function automatic logic [31:0] got();
        got = {24'h000000, spi_master_model_inst.rx_q.pop_front()};
    endfunction
    task automatic pin3(input logic o, input logic n);
        repeat (3) @(posedge core_clk);
        #1;
        chk({30'h00000000, pin_out[3], pin_oe_n[3]}, {30'h00000000, o, n});
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        rd(`OFS_ROUTE_SELECT, `ROUTE_RESET);
        rd(`OFS_ENABLE, `ZERO_RESET);
        rd(12'hFFC, 32'h00000000);
        chk({31'h00000000, e}, 32'h00000001);
        $display("reset test done");
    endtask
    task automatic t_enable;
        wr(`OFS_ROUTE_SELECT, 32'h00000000);
        wr(`OFS_ROUTE_CLOCK, 32'h00000001);
        wr(`OFS_ROUTE_IN, 32'h00000002);
        wr(`OFS_ROUTE_OUT, 32'h00000003);
        wr(12'h880, 32'h00000077);
        wr(12'h888, 32'h00000066);
        wr(12'h800, 32'h0000005A);
        wr(12'h804, 32'h000000C3);
        wr(`OFS_RX_PTR, 32'h00000020);
        wr(`OFS_ENABLE, {28'h0000000, `ENABLE_ON});
        sem(`SEM_CPU);
        rd(`OFS_EV_GRANTED, 32'h00000000);
        rd(12'h804, 32'h000000C3);
        $display("enable test done");
    endtask
    task automatic t_ignored;
        wr(`OFS_IGNORED_FILL, 32'h000000A5);
        fork
            spi_master_model_inst.frame('{8'h12, 8'h34});
            begin
                repeat (100) @(posedge core_clk);
                wr(`OFS_TASK_GIVE, 32'h00000001);
            end
        join
        chk(got(), 32'h000000A5);
        chk(got(), 32'h000000A5);
        rd(12'h880, 32'h00000077);
        rd(`OFS_RX_COUNT, 32'h00000000);
        rd(`OFS_EV_DONE, 32'h00000000);
        sem(`SEM_FREE);
        $display("ignored test done");
    endtask
    task automatic t_granted;
        wr(`OFS_RX_LIMIT, 32'h00000002);
        wr(`OFS_TX_LIMIT, 32'h00000002);
        wr(`OFS_OVERRUN_FILL, 32'h0000003C);
        spi_master_model_inst.frame('{8'h81, 8'h42, 8'h99});
        chk(got(), 32'h0000005A);
        chk(got(), 32'h000000C3);
        chk(got(), 32'h0000003C);
        rd(12'h880, 32'h00000081);
        rd(12'h884, 32'h00000042);
        rd(12'h888, 32'h00000066);
        rd(`OFS_RX_COUNT, 32'h00000002);
        rd(`OFS_TX_COUNT, 32'h00000002);
        rd(`OFS_XFER_STATUS, 32'h00000003);
        rd(`OFS_EV_DONE, 32'h00000001);
        sem(`SEM_FREE);
        wr(`OFS_XFER_STATUS, 32'h00000003);
        wr(`OFS_EV_DONE, 32'h00000000);
        spi_master_model_inst.frame('{8'hE7});
        chk(got(), 32'h0000005A);
        rd(12'h880, 32'h000000E7);
        rd(`OFS_RX_COUNT, 32'h00000001);
        rd(`OFS_XFER_STATUS, 32'h00000000);
        rd(`OFS_EV_DONE, 32'h00000001);
        $display("granted test done");
    endtask
    task automatic t_defer;
        wr(`OFS_EVENT_TASK_SHORTCUTS, 32'h00000001);
        wr(`OFS_EV_GRANTED, 32'h00000000);
        fork
            spi_master_model_inst.frame('{8'h3A});
            begin
                repeat (60) @(posedge core_clk);
                wr(`OFS_TASK_TAKE, 32'h00000001);
                sem(`SEM_SPI_CPU_WAIT);
                wr(`OFS_TASK_GIVE, 32'h00000001);
                sem(`SEM_SPI_CPU_WAIT);
                rd(`OFS_EV_GRANTED, 32'h00000000);
                rd(`OFS_RX_PTR, 32'h00000020);
            end
        join
        spi_master_model_inst.rx_q.delete();
        sem(`SEM_CPU);
        rd(`OFS_EV_GRANTED, 32'h00000001);
        wr(`OFS_EV_GRANTED, 32'h00000000);
        repeat (20) @(posedge core_clk);
        rd(`OFS_EV_GRANTED, 32'h00000000);
        wr(`OFS_TASK_TAKE, 32'h00000001);
        rd(`OFS_EV_GRANTED, 32'h00000001);
        $display("defer test done");
    endtask
    task automatic t_pins;
        wr(`OFS_ENABLE, 32'h00000000);
        gpio_out <= 32'hA5C3F0F8;
        gpio_oe_n <= 32'hFFFFFFF7;
        pin3(1'b1, 1'b0);
        wr(`OFS_ROUTE_OUT, `ROUTE_RESET);
        wr(`OFS_ENABLE, {28'h0000000, `ENABLE_ON});
        pin3(1'b1, 1'b0);
        $display("pin test done");
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        reset_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h00000000;
        gpio_out = 32'hA5C3F0F0;
        gpio_oe_n = 32'hFFFFFFFF;
        error_cnt = 0;
        check_count = 0;
        repeat (10) @(posedge core_clk);
        reset_n <= 1'b1;
        t_reset;
        t_enable;
        t_ignored;
        t_granted;
        t_defer;
        t_pins;
        test_done;
    end
endmodule // spi_slave_buffer_semaphore_tb
